// [dtsb_params.svh]
// offsets, field positions, reset values and sizes of the trace sequencer and buffer
// assumes a 32-bit apb slave decode on the low twelve address bits
`ifndef DTSB_PARAMS_SVH
`define DTSB_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DTSB_CTRL_OFS 12'h000
`define DTSB_STAT_OFS 12'h004
`define DTSB_WIN_OFS 12'h008
`define DTSB_WINH_OFS 12'h00c

// ****************************************************************
// control register fields
// ****************************************************************
`define DTSB_CTRL_ARM 0
`define DTSB_CTRL_TEN 1
`define DTSB_CTRL_MODE_LO 2
`define DTSB_CTRL_SEL_LO 4

// ****************************************************************
// status register fields
// ****************************************************************
`define DTSB_STAT_OVF 7
`define DTSB_STAT_LOCK 8
`define DTSB_STAT_SEQ_LO 9
`define DTSB_STAT_RDOK 12

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define DTSB_DEPTH 64
`define DTSB_LINE_W 20
`define DTSB_FULL_COUNT 8'h40
`define DTSB_DETAIL_MAX 32
`define DTSB_SEL_RESET 3'h0
`define DTSB_MODE_RESET 2'h0

`endif

// [dtsb_pkg.sv]
// types of the trace sequencer and buffer: states, modes and the module state record
// assumes dtsb_params.svh is on the include path
`include "dtsb_params.svh"

package dtsb_pkg;

    // sequencer states; disarmed sits outside the four stages
    typedef enum logic [2:0] {DTSB_DISARMED, DTSB_STATE1, DTSB_STATE2, DTSB_STATE3, DTSB_FINAL} dtsb_seq_t;

    // trace modes in field order 00,01,10,11
    typedef enum logic [1:0] {DTSB_NORMAL, DTSB_LOOP1, DTSB_DETAIL, DTSB_PUREPC} dtsb_mode_t;

    // one buffer line
    typedef logic [`DTSB_LINE_W-1:0] dtsb_line_t;

    // all state of the block
    typedef struct packed {
        dtsb_line_t [`DTSB_DEPTH-1:0] mem;
        logic [5:0] wr_ptr;
        logic [5:0] rd_ptr;
        logic [6:0] valid_line_count;
        logic overflow;
        logic armed;
        logic trace_enable_bit;
        dtsb_mode_t trace_mode_field;
        logic [2:0] state1_next_select;
        logic locked;
        dtsb_seq_t seq;
        logic [17:0] last_src;
        logic last_src_ok;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dtsb_state_t;

endpackage

// [dtsb_debug_unit.sv]
// trace state sequencer (state1 next-state choice) and 64 x 20 bit trace buffer with apb readout
// assumes apb master on core_clk, cpu bus and match inputs synchronous to core_clk
//
// Behaviour
// [RQ1] state1 codes 000..011 pick documented targets
// [RQ2] code 100: match0 to state2, match1 state3
// [RQ3] code 101: match1 state3, match0 final
// [RQ4] code 110: match0 state2, match2 state3
// [RQ5] code 111: match0/1 to state2, match2 ignored
// [RQ6] lowest channel wins, final beats all
// [RQ7] detail records accesses, skips free/fetch cycles
// [RQ8] detail entry is two lines, count +2
// [RQ9] line is 4+8+8 bits wide
// [RQ10] byte data low, word lower-address in byte1
// [RQ11] detail upper field: size bit3, direction bit2
// [RQ12] write 0 read 1, address bits 17:16 low
// [RQ13] pure pc stores every executed opcode address
// [RQ14] cof bit3 source/destination, pc bits 17:16
// [RQ15] vector flag forces destination flag set
// [RQ16] read only disarmed, enabled, unsecured; arm locks
// [RQ17] aligned window word write while disarmed unlocks
// [RQ18] misaligned window reads give zero, no advance
// [RQ19] fifo readout, count never decreases on read
// [RQ20] pointer to oldest after session and high write
// [RQ21] host prefers tagged breakpoints to end tracing
// [RQ22] mode field 00 normal ... 11 pure pc
// [RQ23] trace enable not settable when secured
// [RQ24] select sampled in state1, move next edge
`timescale 1ns/1ns
`include "dtsb_params.svh"

module dtsb_debug_unit
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system security and comparator matches
    input wire logic secured,
    input wire logic [2:0] match,
    // monitored cpu data accesses
    input wire logic cpu_acc_valid,
    input wire logic cpu_free,
    input wire logic cpu_opfetch,
    input wire logic cpu_rnw,
    input wire logic cpu_byte,
    input wire logic [17:0] cpu_addr,
    input wire logic [7:0] cpu_data_lo_addr,
    input wire logic [7:0] cpu_data_hi_addr,
    // monitored change of flow and executed opcodes
    input wire logic cof_valid,
    input wire logic cof_dest,
    input wire logic cof_vector,
    input wire logic [17:0] cof_addr,
    input wire logic exec_valid,
    input wire logic [17:0] exec_pc,
    // sequencer state
    output dtsb_pkg::dtsb_seq_t seq_state
);

    // ************
    // functions
    // ************

    // state1 next state from select code and matches; returns state1 when nothing qualifies
    function automatic dtsb_pkg::dtsb_seq_t state1_next(input logic [2:0] sel, input logic [2:0] m);
        dtsb_pkg::dtsb_seq_t r;
        r = dtsb_pkg::DTSB_STATE1;
        case (sel)
            3'h0: if (|m) r = dtsb_pkg::DTSB_FINAL; // RQ1 RQ6
            3'h1: if (m[1]) r = dtsb_pkg::DTSB_STATE3; // RQ1
            3'h2: if (m[2]) r = dtsb_pkg::DTSB_STATE2; // RQ1
            3'h3: if (m[1]) r = dtsb_pkg::DTSB_STATE2; // RQ1
            3'h4:
            begin
                // lower channel first
                if (m[0]) r = dtsb_pkg::DTSB_STATE2; // RQ2 RQ6
                else if (m[1]) r = dtsb_pkg::DTSB_STATE3; // RQ2
            end
            3'h5:
            begin
                // final state outranks the other match
                if (m[0]) r = dtsb_pkg::DTSB_FINAL; // RQ3 RQ6
                else if (m[1]) r = dtsb_pkg::DTSB_STATE3; // RQ3
            end
            3'h6:
            begin
                if (m[0]) r = dtsb_pkg::DTSB_STATE2; // RQ4 RQ6
                else if (m[2]) r = dtsb_pkg::DTSB_STATE3; // RQ4
            end
            default:
            begin
                // match2 has no effect here
                if (m[0] | m[1]) r = dtsb_pkg::DTSB_STATE2; // RQ5
            end
        endcase
        return r;
    endfunction

    // buffer may be read: disarmed, enabled, unsecured, unlocked
    function automatic logic read_ok(input dtsb_pkg::dtsb_state_t s, input logic sec);
        return !s.armed && s.trace_enable_bit && !sec && !s.locked; // RQ16 RQ23
    endfunction

    // line holding the oldest entry
    function automatic logic [5:0] oldest(input dtsb_pkg::dtsb_state_t s);
        return s.overflow ? s.wr_ptr : 6'h00; // RQ20
    endfunction

    // ************
    // state
    // ************

    dtsb_pkg::dtsb_state_t st; // registered state
    dtsb_pkg::dtsb_state_t next_st; // next state
    logic [11:0] a_ofs; // decoded word offset
    logic a_mis; // misaligned address
    logic acc; // apb access phase
    logic done; // apb transfer completes this edge
    logic rec; // recording into the buffer
    logic [7:0] sum; // line count plus lines written
    logic [1:0] nlines; // lines written this cycle
    dtsb_pkg::dtsb_line_t line0; // first line written
    dtsb_pkg::dtsb_line_t line1; // second line (detail data)

    assign a_ofs = {paddr[11:2], 2'b00};
    assign a_mis = |paddr[1:0];
    assign acc = psel && penable;
    assign done = acc && st.pready;

    // outputs straight from the state record
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign seq_state = st.seq;

    // ************
    // next state
    // ************

    // bus slave, sequencer and trace recording
    always_comb
    begin
        next_st = st;
        nlines = 2'h0;
        line0 = '0;
        line1 = '0;
        sum = 8'h00;
        rec = (st.seq == dtsb_pkg::DTSB_FINAL) && st.trace_enable_bit && !secured;

        // apb answer one cycle into the access phase
        next_st.pready = acc && !st.pready;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0;
        if (acc && !st.pready)
        begin
            if (a_ofs == `DTSB_CTRL_OFS)
            begin
                // control readback
                next_st.prdata[`DTSB_CTRL_ARM] = st.armed;
                next_st.prdata[`DTSB_CTRL_TEN] = st.trace_enable_bit;
                next_st.prdata[`DTSB_CTRL_MODE_LO+:2] = st.trace_mode_field;
                next_st.prdata[`DTSB_CTRL_SEL_LO+:3] = st.state1_next_select;
            end
            else if (a_ofs == `DTSB_STAT_OFS)
            begin
                // line count and state
                next_st.prdata[6:0] = st.valid_line_count; // RQ19
                next_st.prdata[`DTSB_STAT_OVF] = st.overflow;
                next_st.prdata[`DTSB_STAT_LOCK] = st.locked;
                next_st.prdata[`DTSB_STAT_SEQ_LO+:3] = st.seq;
                next_st.prdata[`DTSB_STAT_RDOK] = read_ok(st, secured);
            end
            else if (a_ofs == `DTSB_WIN_OFS)
            begin
                // only aligned readable accesses return a line
                if (!pwrite && !a_mis && read_ok(st, secured)) // RQ16 RQ18
                    next_st.prdata[19:0] = st.mem[st.rd_ptr]; // RQ19
            end
            else if (a_ofs == `DTSB_WINH_OFS)
            begin
                // write-only pointer reset, reads zero
                next_st.prdata = 32'h0;
            end
            else
            begin
                // unmapped
                next_st.pslverr = 1'b1;
            end
        end

        // state1 transitions, select sampled only in state1
        if (st.seq == dtsb_pkg::DTSB_STATE1)
            next_st.seq = state1_next(st.state1_next_select, match); // RQ24

        // build the lines for this cycle
        if (rec)
        begin
            if (st.trace_mode_field == dtsb_pkg::DTSB_DETAIL)
            begin
                // free and opcode fetch cycles are skipped
                if (cpu_acc_valid && !cpu_free && !cpu_opfetch) // RQ7
                begin
                    nlines = 2'h2; // RQ8
                    line0 = {cpu_byte, cpu_rnw, cpu_addr}; // RQ9 RQ11 RQ12
                    if (cpu_byte)
                        line1 = {4'h0, 8'h00, cpu_data_lo_addr}; // RQ10
                    else
                        line1 = {4'h0, cpu_data_lo_addr, cpu_data_hi_addr}; // RQ10
                end
            end
            else if (st.trace_mode_field == dtsb_pkg::DTSB_PUREPC)
            begin
                // every executed opcode, flags meaningless and zero
                if (exec_valid) // RQ13
                begin
                    nlines = 2'h1;
                    line0 = {2'b00, exec_pc}; // RQ13 RQ14
                end
            end
            else if (cof_valid)
            begin
                // normal and loop1; loop1 drops repeated source addresses
                if (!(st.trace_mode_field == dtsb_pkg::DTSB_LOOP1 && !cof_dest && !cof_vector
                      && st.last_src_ok && st.last_src == cof_addr)) // RQ22
                begin
                    nlines = 2'h1;
                    line0 = {cof_dest | cof_vector, cof_vector, cof_addr}; // RQ14 RQ15
                end
                if (!cof_dest && !cof_vector)
                begin
                    next_st.last_src = cof_addr;
                    next_st.last_src_ok = 1'b1;
                end
            end
        end

        // store lines and advance the count, saturating at full
        if (nlines != 2'h0)
        begin
            next_st.mem[st.wr_ptr] = line0;
            if (nlines == 2'h2)
                next_st.mem[6'(st.wr_ptr + 6'h1)] = line1; // RQ8
            next_st.wr_ptr = 6'(st.wr_ptr + {4'h0, nlines});
            sum = {1'b0, st.valid_line_count} + {6'h00, nlines};
            if (sum > `DTSB_FULL_COUNT)
            begin
                next_st.valid_line_count = 7'(`DTSB_FULL_COUNT);
                next_st.overflow = 1'b1;
            end
            else
            begin
                next_st.valid_line_count = sum[6:0]; // RQ8
                next_st.overflow = st.overflow || (sum == `DTSB_FULL_COUNT && st.wr_ptr != 6'h00);
            end
        end

        // register writes take effect when the transfer completes
        if (done && pwrite)
        begin
            if (a_ofs == `DTSB_CTRL_OFS && pstrb[0])
            begin
                if (!st.armed)
                begin
                    // configuration only while disarmed
                    next_st.trace_mode_field = dtsb_pkg::dtsb_mode_t'(pwdata[`DTSB_CTRL_MODE_LO+:2]); // RQ22
                    next_st.state1_next_select = pwdata[`DTSB_CTRL_SEL_LO+:3];
                    next_st.trace_enable_bit = pwdata[`DTSB_CTRL_TEN] && !secured; // RQ23
                end
                if (pwdata[`DTSB_CTRL_ARM] && !st.armed)
                begin
                    // arming starts a new session and locks reads
                    next_st.armed = 1'b1;
                    next_st.locked = 1'b1; // RQ16
                    next_st.seq = dtsb_pkg::DTSB_STATE1;
                    next_st.wr_ptr = 6'h00;
                    next_st.valid_line_count = 7'h00;
                    next_st.overflow = 1'b0;
                    next_st.last_src_ok = 1'b0;
                end
                else if (!pwdata[`DTSB_CTRL_ARM] && st.armed)
                begin
                    // disarm ends the session, pointer to oldest entry
                    next_st.armed = 1'b0;
                    next_st.seq = dtsb_pkg::DTSB_DISARMED;
                    next_st.rd_ptr = oldest(next_st); // RQ20
                end
            end
            else if (a_ofs == `DTSB_WIN_OFS && !a_mis && pstrb == 4'hf && !st.armed)
            begin
                // single aligned word write unlocks
                next_st.locked = 1'b0; // RQ17
            end
            else if (a_ofs == `DTSB_WINH_OFS && !a_mis && pstrb[0])
            begin
                // restart readout from the oldest entry
                next_st.rd_ptr = oldest(st); // RQ20
            end
        end
        else if (done && a_ofs == `DTSB_WIN_OFS && !a_mis && read_ok(st, secured))
        begin
            // aligned read moves to the next line, count untouched
            next_st.rd_ptr = 6'(st.rd_ptr + 6'h1); // RQ19
        end
    end

    // ************
    // registers
    // ************

    // synchronous active-low reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.seq <= dtsb_pkg::DTSB_DISARMED;
            st.trace_mode_field <= dtsb_pkg::dtsb_mode_t'(`DTSB_MODE_RESET);
            st.state1_next_select <= `DTSB_SEL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************
    // assertions
    // ************

    logic ctrl_wr; // control write completing
    assign ctrl_wr = done && pwrite && a_ofs == `DTSB_CTRL_OFS;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sel_any_final_a: assert property ((st.seq == dtsb_pkg::DTSB_STATE1 && st.state1_next_select == 3'h0 && |match
        && !ctrl_wr) |=> st.seq == dtsb_pkg::DTSB_FINAL) else $error("code 000 match not to final"); // RQ1
    sel_m0_state2_a: assert property ((st.seq == dtsb_pkg::DTSB_STATE1 && st.state1_next_select == 3'h4 && match[0]
        && !ctrl_wr) |=> st.seq == dtsb_pkg::DTSB_STATE2) else $error("code 100 match0 wrong"); // RQ2
    sel_final_prio_a: assert property ((st.seq == dtsb_pkg::DTSB_STATE1 && st.state1_next_select == 3'h5
        && match[1:0] == 2'b11 && !ctrl_wr) |=> st.seq == dtsb_pkg::DTSB_FINAL) else $error("final not first"); // RQ3
    sel_m2_state3_a: assert property ((st.seq == dtsb_pkg::DTSB_STATE1 && st.state1_next_select == 3'h6
        && match == 3'b100 && !ctrl_wr) |=> st.seq == dtsb_pkg::DTSB_STATE3) else $error("code 110 match2 wrong"); // RQ4
    sel_m2_ignored_a: assert property ((st.seq == dtsb_pkg::DTSB_STATE1 && st.state1_next_select == 3'h7
        && match == 3'b100 && !ctrl_wr) |=> st.seq == dtsb_pkg::DTSB_STATE1) else $error("code 111 match2 acted"); // RQ5
    detail_two_lines_a: assert property ((rec && st.trace_mode_field == dtsb_pkg::DTSB_DETAIL && cpu_acc_valid
        && !cpu_free && !cpu_opfetch && st.valid_line_count <= 7'd62 && !ctrl_wr)
        |=> st.valid_line_count == $past(st.valid_line_count) + 7'd2) else $error("detail count not plus two"); // RQ8
    misaligned_zero_a: assert property ((acc && !st.pready && !pwrite && a_ofs == `DTSB_WIN_OFS && a_mis)
        |=> st.prdata == 32'h0 ##1 st.rd_ptr == $past(st.rd_ptr, 2)) else $error("misaligned read not zero"); // RQ18
    armed_locked_a: assert property ((acc && !st.pready && !pwrite && a_ofs == `DTSB_WIN_OFS // RQ16
        && (st.armed || st.locked)) |=> st.prdata == 32'h0) else $error("locked buffer read data");
    count_steady_a: assert property ((st.seq != dtsb_pkg::DTSB_FINAL && !ctrl_wr)
        |=> $stable(st.valid_line_count)) else $error("count moved outside tracing"); // RQ19
    winh_restart_a: assert property ((done && pwrite && a_ofs == `DTSB_WINH_OFS && !a_mis && pstrb[0])
        |=> st.rd_ptr == ($past(st.overflow) ? $past(st.wr_ptr) : 6'h00)) else $error("pointer not to oldest"); // RQ20
    vector_dest_a: assert property ((rec && st.trace_mode_field == dtsb_pkg::DTSB_NORMAL && cof_valid && cof_vector)
        |=> st.mem[$past(st.wr_ptr)][19:18] == 2'b11) else $error("vector without destination"); // RQ15
    secured_enable_a: assert property ((ctrl_wr && pstrb[0] && secured && !st.armed) // RQ23
        |=> !st.trace_enable_bit) else $error("enable set while secured");

    final_reached_c: cover property (st.seq == dtsb_pkg::DTSB_STATE1 ##1 st.seq == dtsb_pkg::DTSB_FINAL);
    detail_record_c: cover property (rec && st.trace_mode_field == dtsb_pkg::DTSB_DETAIL && cpu_acc_valid);
    overflow_c: cover property (!st.overflow ##1 st.overflow);
    window_read_c: cover property (done && !pwrite && a_ofs == `DTSB_WIN_OFS && st.prdata != 32'h0);

endmodule

// [dtsb_cpu_model.sv]
// monitored cpu bus and comparator matches, driven as the cpu core would drive them
// assumes the caller runs every task from the bench, one task at a time, on core_clk
`timescale 1ns/1ns

module dtsb_cpu_model
(
    // clock
    input wire logic core_clk,
    // comparator matches
    output logic [2:0] match,
    // data accesses
    output logic cpu_acc_valid,
    output logic cpu_free,
    output logic cpu_opfetch,
    output logic cpu_rnw,
    output logic cpu_byte,
    output logic [17:0] cpu_addr,
    output logic [7:0] cpu_data_lo_addr,
    output logic [7:0] cpu_data_hi_addr,
    // change of flow and executed opcodes
    output logic cof_valid,
    output logic cof_dest,
    output logic cof_vector,
    output logic [17:0] cof_addr,
    output logic exec_valid,
    output logic [17:0] exec_pc
);
    // ****************************************************************
    // idle values at time zero
    // ****************************************************************
    initial
    begin
        {match, cpu_acc_valid, cpu_free, cpu_opfetch, cpu_rnw, cpu_byte} = '0;
        {cpu_addr, cpu_data_lo_addr, cpu_data_hi_addr} = '0;
        {cof_valid, cof_dest, cof_vector, cof_addr, exec_valid, exec_pc} = '0;
    end

    // one access cycle; the bus shows inverted stale values afterwards
    task automatic acc(input logic fr, fe, rnw, byt, input logic [17:0] a, input logic [7:0] lo, hi);
        @(posedge core_clk);
        {cpu_acc_valid, cpu_free, cpu_opfetch, cpu_rnw, cpu_byte} <= {1'b1, fr, fe, rnw, byt};
        {cpu_addr, cpu_data_lo_addr, cpu_data_hi_addr} <= {a, lo, hi};
        @(posedge core_clk);
        cpu_acc_valid <= 1'b0;
        {cpu_addr, cpu_data_lo_addr, cpu_data_hi_addr} <= ~{a, lo, hi};
    endtask

    // one change of flow address; a vector address is always a destination
    task automatic cof(input logic vec, dst, input logic [17:0] a);
        @(posedge core_clk);
        {cof_valid, cof_dest, cof_vector, cof_addr} <= {1'b1, dst | vec, vec, a};
        @(posedge core_clk);
        cof_valid <= 1'b0;
        cof_addr <= ~a;
    endtask

    // one executed opcode
    task automatic exe(input logic [17:0] pc);
        @(posedge core_clk);
        {exec_valid, exec_pc} <= {1'b1, pc};
        @(posedge core_clk);
        exec_valid <= 1'b0;
        exec_pc <= ~pc;
    endtask

    // one cycle of comparator matches
    task automatic hit(input logic [2:0] m);
        @(posedge core_clk);
        match <= m;
        @(posedge core_clk);
        match <= 3'h0;
    endtask
endmodule

// [dtsb_debug_unit_tb.sv]
// self-checking bench of the trace sequencer and buffer: apb host tasks and cpu bus model
// assumes the design answers apb with one wait state and resets synchronously
`timescale 1ns/1ns
`include "dtsb_params.svh"

module dtsb_debug_unit_tb;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, secured;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] match;
    logic cpu_acc_valid, cpu_free, cpu_opfetch, cpu_rnw, cpu_byte, cof_valid, cof_dest, cof_vector, exec_valid;
    logic [17:0] cpu_addr, cof_addr, exec_pc;
    logic [7:0] cpu_data_lo_addr, cpu_data_hi_addr;
    dtsb_pkg::dtsb_seq_t seq_state;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    // ************
    // design, cpu model, clock and timeout
    // ************
    dtsb_debug_unit i_dtsb_debug_unit (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secured(secured), .match(match), .cpu_acc_valid(cpu_acc_valid), .cpu_free(cpu_free),
        .cpu_opfetch(cpu_opfetch), .cpu_rnw(cpu_rnw), .cpu_byte(cpu_byte), .cpu_addr(cpu_addr),
        .cpu_data_lo_addr(cpu_data_lo_addr), .cpu_data_hi_addr(cpu_data_hi_addr), .cof_valid(cof_valid),
        .cof_dest(cof_dest), .cof_vector(cof_vector), .cof_addr(cof_addr), .exec_valid(exec_valid),
        .exec_pc(exec_pc), .seq_state(seq_state));
    dtsb_cpu_model i_dtsb_cpu_model (.core_clk(core_clk), .match(match), .cpu_acc_valid(cpu_acc_valid),
        .cpu_free(cpu_free), .cpu_opfetch(cpu_opfetch), .cpu_rnw(cpu_rnw), .cpu_byte(cpu_byte),
        .cpu_addr(cpu_addr), .cpu_data_lo_addr(cpu_data_lo_addr), .cpu_data_hi_addr(cpu_data_hi_addr),
        .cof_valid(cof_valid), .cof_dest(cof_dest), .cof_vector(cof_vector), .cof_addr(cof_addr),
        .exec_valid(exec_valid), .exec_pc(exec_pc));

    // 250 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard: far above the few hundred cycles the tests need
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            test_done();
        end
    end

    // ************
    // shared tasks
    // ************
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, s, q, e);
    endtask

    // read and compare data and error response
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    // configure disarmed, arm, and trigger the final state with match0
    task automatic session(input logic [31:0] cfg);
        wr(`DTSB_CTRL_OFS, cfg, 4'h1);
        wr(`DTSB_CTRL_OFS, cfg | 32'h1, 4'h1);
        i_dtsb_cpu_model.hit(3'h1);
    endtask

    // ************
    // scenarios
    // ************
    // every state1 select code, with simultaneous matches where priority matters
    task automatic t_seq();
        logic [2:0] mv [8] = '{3'h4, 3'h2, 3'h4, 3'h2, 3'h3, 3'h3, 3'h5, 3'h4};
        int ex [8] = '{4, 3, 2, 2, 2, 4, 2, 1};
        for (int c = 0; c < 8; c++)
        begin
            wr(`DTSB_CTRL_OFS, c << 4, 4'h1);
            wr(`DTSB_CTRL_OFS, (c << 4) | 1, 4'h1);
            i_dtsb_cpu_model.hit(mv[c]);
            @(negedge core_clk);
            chk({29'h0, seq_state}, ex[c]);
        end
        wr(`DTSB_CTRL_OFS, 32'h0, 4'h1);
        $display("test seq done");
    endtask

    // detail capture, lock, unlock, misaligned read, fifo order and pointer restart
    task automatic t_detail();
        rd(`DTSB_STAT_OFS, 32'h100, 1'b0);
        session(32'h0a);
        i_dtsb_cpu_model.acc(1'b1, 1'b0, 1'b1, 1'b1, 18'h00100, 8'h77, 8'h66);
        i_dtsb_cpu_model.acc(1'b0, 1'b1, 1'b1, 1'b0, 18'h00200, 8'h55, 8'h44);
        i_dtsb_cpu_model.acc(1'b0, 1'b0, 1'b1, 1'b1, 18'h21234, 8'h5a, 8'ha5);
        i_dtsb_cpu_model.acc(1'b0, 1'b0, 1'b0, 1'b0, 18'h10abc, 8'h11, 8'h22);
        wr(`DTSB_CTRL_OFS, 32'h0a, 4'h1);
        rd(`DTSB_STAT_OFS, 32'h104, 1'b0);
        rd(`DTSB_WIN_OFS, 32'h0, 1'b0);
        wr(`DTSB_WIN_OFS, 32'h0, 4'hf);
        rd(`DTSB_WIN_OFS + 1, 32'h0, 1'b0);
        rd(`DTSB_WIN_OFS, 32'he1234, 1'b0);
        rd(`DTSB_WIN_OFS, 32'h0005a, 1'b0);
        rd(`DTSB_WIN_OFS, 32'h10abc, 1'b0);
        rd(`DTSB_WIN_OFS, 32'h01122, 1'b0);
        wr(`DTSB_WINH_OFS, 32'h0, 4'h1);
        rd(`DTSB_WIN_OFS, 32'he1234, 1'b0);
        rd(`DTSB_STAT_OFS, 32'h1004, 1'b0);
        rd(32'h10, 32'h0, 1'b1);
        $display("test detail done");
    endtask

    // change of flow and pure pc formats, then the secured lockout
    task automatic t_flow();
        session(32'h02);
        i_dtsb_cpu_model.cof(1'b0, 1'b0, 18'h01111);
        i_dtsb_cpu_model.cof(1'b1, 1'b0, 18'h3ffe0);
        wr(`DTSB_CTRL_OFS, 32'h02, 4'h1);
        wr(`DTSB_WIN_OFS, 32'h0, 4'hf);
        rd(`DTSB_WIN_OFS, 32'h01111, 1'b0);
        rd(`DTSB_WIN_OFS, 32'hfffe0, 1'b0);
        session(32'h06);
        i_dtsb_cpu_model.cof(1'b0, 1'b0, 18'h00222);
        i_dtsb_cpu_model.cof(1'b0, 1'b0, 18'h00222);
        wr(`DTSB_CTRL_OFS, 32'h06, 4'h1);
        rd(`DTSB_STAT_OFS, 32'h101, 1'b0);
        session(32'h0e);
        i_dtsb_cpu_model.exe(18'h20004);
        wr(`DTSB_CTRL_OFS, 32'h0e, 4'h1);
        wr(`DTSB_WIN_OFS, 32'h0, 4'hf);
        rd(`DTSB_WIN_OFS, 32'h20004, 1'b0);
        @(posedge core_clk);
        secured <= 1'b1;
        wr(`DTSB_WINH_OFS, 32'h0, 4'h1);
        rd(`DTSB_WIN_OFS, 32'h0, 1'b0);
        wr(`DTSB_CTRL_OFS, 32'h0e, 4'h1);
        rd(`DTSB_CTRL_OFS, 32'h0c, 1'b0);
        $display("test flow done");
    endtask

    // ************
    // main sequence
    // ************
    initial
    begin
        {resetn, psel, penable, pwrite, secured, paddr, pwdata, pstrb} = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_seq();
        t_detail();
        t_flow();
        test_done();
    end
endmodule
